/* File: core/mdiv_unit.sv */
// multiply/divide unit: booth multiply pipeline, accumulator pairs, divider
`timescale 1ns/10ps
`include "mdiv_params.svh"

module mdiv_unit #(
    parameter int PAIRS       = `MDIV_PAIRS,        // accumulator pairs
    parameter int MUL_LATENCY = `MDIV_MUL_LATENCY   // clocks issue to result
) (
    input  wire logic                       clk,           // core clock
    input  wire logic                       rstn,          // async reset, low
    input  wire logic                       issueValid,    // operation offered
    input  wire mdiv_pkg::mdiv_op_t         issueOp,       // operation code
    input  wire logic                       issueSigned,   // signed variant
    input  wire logic [$clog2(PAIRS)-1:0]   issuePair,     // target pair
    input  wire logic [`MDIV_DEST_BITS-1:0] issueDest,     // general reg index
    input  wire logic [31:0]                firstOperand,  // multiplicand/dividend
    input  wire logic [31:0]                secondOperand, // multiplier/divisor
    input  wire logic [$clog2(PAIRS)-1:0]   readPair,      // pair to show
    output logic                            issueStall,    // hold issue, divide busy
    output logic                            gprValid,      // general result pulse
    output logic [`MDIV_DEST_BITS-1:0]      gprDest,       // its register index
    output logic [31:0]                     gprData,       // its value
    output logic                            divDone,       // divide written pulse
    output logic [31:0]                     readUpper,     // upper of readPair
    output logic [31:0]                     readLower      // lower of readPair
);

    localparam int PSEL   = $clog2(PAIRS);
    localparam int STAGES = MUL_LATENCY - 1;

    // ======================================================================
    // elaboration checks
    // product needs its own stage after operand capture
    if (MUL_LATENCY < 3) begin : gLatencyCheck
        $error("mdiv_unit: MUL_LATENCY must be at least 3");
    end
    // a one-pair unit would need a zero-width select
    if (PAIRS < 2) begin : gPairCheck
        $error("mdiv_unit: PAIRS must be at least 2");
    end

    // ======================================================================
    // booth radix-4 multiply of two 33-bit two's complement numbers
    function automatic logic [63:0] boothMul(input logic [32:0] a, input logic [32:0] b);
        logic [65:0] acc;
        logic [65:0] aExt;
        logic [34:0] bExt;
        logic [2:0]  dig;
        acc  = 66'h0;
        aExt = {{33{a[32]}}, a};
        bExt = {b[32], b, 1'b0};
        for (int i = 0; i < 17; i++) begin
            dig = bExt[2*i +: 3];
            case (dig)
                3'h1, 3'h2: acc = acc + (aExt << (2*i));
                3'h3:       acc = acc + (aExt << (2*i + 1));
                3'h4:       acc = acc - (aExt << (2*i + 1));
                3'h5, 3'h6: acc = acc - (aExt << (2*i));
                default:    acc = acc;
            endcase
        end
        return acc[63:0];
    endfunction

    // product per operation; dual halfword forms sum two signed 16x16 products
    function automatic logic [63:0] mulProduct(input logic [31:0] a, input logic [31:0] b,
                                               input mdiv_pkg::mdiv_op_t op,
                                               input logic sgn);
        logic [63:0] lo;
        logic [63:0] hi;
        lo = boothMul({{17{a[15]}}, a[15:0]}, {{17{b[15]}}, b[15:0]});
        hi = boothMul({{17{a[31]}}, a[31:16]}, {{17{b[31]}}, b[31:16]});
        if (op == mdiv_pkg::OP_SPX_DOT_ADD || op == mdiv_pkg::OP_SPX_DOT_SUB) begin
            return lo + hi;
        end else if (op == mdiv_pkg::OP_MOVE_UPPER || op == mdiv_pkg::OP_MOVE_LOWER) begin
            return {32'h0, a};
        end
        return boothMul({sgn & a[31], a}, {sgn & b[31], b});
    endfunction

    // ======================================================================
    // issue acceptance
    logic mulAccept;
    logic divAccept;
    logic divFire;
    logic [31:0] divQuotient;
    logic [31:0] divRemainder;
    logic [PSEL-1:0] divPair;

    // the stall flag is registered, so an op in the cycle a divide is taken
    // still goes; the partner sees the flag from the next cycle on
    always_comb begin
        divAccept = issueValid && !issueStall && issueOp == mdiv_pkg::OP_DIVIDE;
        mulAccept = issueValid && !issueStall && issueOp != mdiv_pkg::OP_DIVIDE;
    end

    // stall held from the edge that takes a divide to the edge that writes it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            issueStall <= 1'b0;
        end else if (divAccept) begin
            issueStall <= 1'b1;
        end else if (divFire) begin
            issueStall <= 1'b0;
        end
    end

    // pair chosen by the divide in flight
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            divPair <= '0;
        end else if (divAccept) begin
            divPair <= issuePair;
        end
    end

    // ======================================================================
    // multiply pipeline; no stall input, so it always advances
    logic                       sValid  [STAGES];
    mdiv_pkg::mdiv_op_t         sOp     [STAGES];
    logic                       sSigned [STAGES];
    logic [PSEL-1:0]            sPair   [STAGES];
    logic [`MDIV_DEST_BITS-1:0] sDest   [STAGES];
    logic [63:0]                sProd   [STAGES];
    logic [31:0]                sA;
    logic [31:0]                sB;

    // stage one captures operands; size of the second operand needs no
    // special path because both widths share the same latency
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sA <= 32'h0;
            sB <= 32'h0;
        end else if (mulAccept) begin
            sA <= firstOperand;
            sB <= secondOperand;
        end
    end

    // control travels with the data through every stage
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int k = 0; k < STAGES; k++) begin
                sValid[k]  <= 1'b0;
                sOp[k]     <= mdiv_pkg::OP_MUL_PAIR;
                sSigned[k] <= 1'b0;
                sPair[k]   <= '0;
                sDest[k]   <= '0;
            end
        end else begin
            sValid[0]  <= mulAccept;
            sOp[0]     <= issueOp;
            sSigned[0] <= issueSigned;
            sPair[0]   <= issuePair;
            sDest[0]   <= issueDest;
            for (int k = 1; k < STAGES; k++) begin
                sValid[k]  <= sValid[k-1];
                sOp[k]     <= sOp[k-1];
                sSigned[k] <= sSigned[k-1];
                sPair[k]   <= sPair[k-1];
                sDest[k]   <= sDest[k-1];
            end
        end
    end

    // stage two forms the product; later stages only delay it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int k = 0; k < STAGES; k++) begin
                sProd[k] <= 64'h0;
            end
        end else begin
            sProd[0] <= 64'h0;
            sProd[1] <= mulProduct(sA, sB, sOp[0], sSigned[0]);
            for (int k = 2; k < STAGES; k++) begin
                sProd[k] <= sProd[k-1];
            end
        end
    end

    // ======================================================================
    // accumulator pairs and final write
    logic [63:0] accPair [PAIRS];
    logic [63:0] mulResult;
    logic [63:0] pairNow;
    logic        lastValid;
    logic        writesPair;

    // accumulate reads the pair in the last stage, so a back-to-back
    // accumulate on the same pair already sees the previous write
    always_comb begin
        lastValid  = sValid[STAGES-1];
        pairNow    = accPair[sPair[STAGES-1]];
        writesPair = lastValid && sOp[STAGES-1] != mdiv_pkg::OP_MUL_GPR;
        unique case (sOp[STAGES-1])
            mdiv_pkg::OP_MUL_ACC,
            mdiv_pkg::OP_SPX_DOT_ADD: mulResult = pairNow + sProd[STAGES-1];
            mdiv_pkg::OP_MUL_SUB,
            mdiv_pkg::OP_SPX_DOT_SUB: mulResult = pairNow - sProd[STAGES-1];
            mdiv_pkg::OP_MOVE_UPPER:  mulResult = {sProd[STAGES-1][31:0], pairNow[31:0]};
            mdiv_pkg::OP_MOVE_LOWER:  mulResult = {pairNow[63:32], sProd[STAGES-1][31:0]};
            default:                  mulResult = sProd[STAGES-1];
        endcase
    end

    // moves go through the pipe too, keeping order with multiplies in flight;
    // a divide cannot end while a multiply writes, but it would win if it did
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int p = 0; p < PAIRS; p++) begin
                accPair[p] <= 64'h0;
            end
        end else if (divFire) begin
            accPair[divPair] <= {divRemainder, divQuotient};
        end else if (writesPair) begin
            accPair[sPair[STAGES-1]] <= mulResult;
        end
    end

    // general register result, one pulse on the fifth edge after issue
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gprValid <= 1'b0;
            gprDest  <= '0;
            gprData  <= 32'h0;
        end else begin
            gprValid <= lastValid && sOp[STAGES-1] == mdiv_pkg::OP_MUL_GPR;
            gprDest  <= sDest[STAGES-1];
            gprData  <= sProd[STAGES-1][31:0];
        end
    end

    // ======================================================================
    // divider
    mdiv_divider uDivider (
        .clk       (clk),
        .rstn      (rstn),
        .start     (divAccept),
        .signedOp  (issueSigned),
        .dividend  (firstOperand),
        .divisor   (secondOperand),
        .done      (divFire),
        .quotient  (divQuotient),
        .remainder (divRemainder)
    );

    // completion pulse, aligned with the pair write becoming visible
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            divDone <= 1'b0;
        end else begin
            divDone <= divFire;
        end
    end

    // ======================================================================
    // read port: one clock behind the select, so it shows writes a clock late
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            readUpper <= 32'h0;
            readLower <= 32'h0;
        end else begin
            readUpper <= accPair[readPair][63:32];
            readLower <= accPair[readPair][31:0];
        end
    end

endmodule

/* File: core/mdiv_params.svh */
// timing, size and field constants of the multiply/divide unit
`ifndef MDIV_PARAMS_SVH
`define MDIV_PARAMS_SVH

// ==========================================================================
// datapath sizes
`define MDIV_WIDTH          32
`define MDIV_PAIRS          4
`define MDIV_DEST_BITS      5

// ==========================================================================
// multiply pipeline: clocks from issue to a visible result, and issue spacing
`define MDIV_MUL_LATENCY    5
`define MDIV_MUL_REPEAT     1

// ==========================================================================
// divider early-in: iterations skipped per dividend width class
`define MDIV_SKIP_8         6'h17
`define MDIV_SKIP_16        6'h0F
`define MDIV_SKIP_24        6'h07
`define MDIV_SKIP_32        6'h00
`define MDIV_DIV_BITS       6'h20

// ==========================================================================
// divide latency (equal to repeat) per class, unsigned then signed
`define MDIV_DIV_LAT_U8     6'h0C
`define MDIV_DIV_LAT_S8     6'h0E
`define MDIV_DIV_LAT_U16    6'h14
`define MDIV_DIV_LAT_S16    6'h16
`define MDIV_DIV_LAT_U24    6'h1C
`define MDIV_DIV_LAT_S24    6'h1E
`define MDIV_DIV_LAT_U32    6'h24
`define MDIV_DIV_LAT_S32    6'h26

`endif

/* File: core/mdiv_pkg.sv */
// types shared by the multiply/divide unit files
package mdiv_pkg;

    // ======================================================================
    // operations the integer pipeline may issue
    typedef enum logic [3:0] {
        OP_MUL_PAIR,
        OP_MUL_ACC,
        OP_MUL_SUB,
        OP_MUL_GPR,
        OP_DIVIDE,
        OP_SPX_DOT_ADD,
        OP_SPX_DOT_SUB,
        OP_MOVE_UPPER,
        OP_MOVE_LOWER
    } mdiv_op_t;

    // ======================================================================
    // divider sequencer states
    typedef enum logic {
        DIV_IDLE,
        DIV_RUN
    } mdiv_div_state_t;

endpackage

/* File: core/mdiv_divider.sv */
// iterative one-bit-per-clock divider with early-in on the dividend width
`timescale 1ns/10ps
`include "mdiv_params.svh"

module mdiv_divider (
    input  wire logic        clk,       // core clock
    input  wire logic        rstn,      // async reset, active low
    input  wire logic        start,     // one-cycle pulse: take operands
    input  wire logic        signedOp,  // two's complement divide
    input  wire logic [31:0] dividend,  // first operand
    input  wire logic [31:0] divisor,   // second operand
    output logic             done,      // one-cycle pulse on the final edge
    output logic [31:0]      quotient,  // valid while done
    output logic [31:0]      remainder  // valid while done
);

    // ======================================================================
    // operand preparation
    mdiv_pkg::mdiv_div_state_t state;
    logic [5:0]  cycLeft;
    logic [5:0]  itersLeft;
    logic [31:0] rem;
    logic [31:0] quo;
    logic [31:0] dvsr;
    logic        negQ;
    logic        negR;
    logic [31:0] magDividend;
    logic [31:0] magDivisor;
    logic [5:0]  skip;
    logic [5:0]  latency;
    logic [32:0] shifted;
    logic [33:0] trial;

    // magnitudes; -2^31 maps to 2^31, which still fits the unsigned path
    always_comb begin
        magDividend = (signedOp && dividend[31]) ? (32'h0 - dividend) : dividend;
        magDivisor  = (signedOp && divisor[31]) ? (32'h0 - divisor) : divisor;
    end

    // width class from the sign extension of the dividend
    always_comb begin
        if (signedOp ? (&dividend[31:7] || ~|dividend[31:7]) : ~|dividend[31:8]) begin
            skip    = `MDIV_SKIP_8;
            latency = signedOp ? `MDIV_DIV_LAT_S8 : `MDIV_DIV_LAT_U8;
        end else if (signedOp ? (&dividend[31:15] || ~|dividend[31:15])
                              : ~|dividend[31:16]) begin
            skip    = `MDIV_SKIP_16;
            latency = signedOp ? `MDIV_DIV_LAT_S16 : `MDIV_DIV_LAT_U16;
        end else if (signedOp ? (&dividend[31:23] || ~|dividend[31:23])
                              : ~|dividend[31:24]) begin
            skip    = `MDIV_SKIP_24;
            latency = signedOp ? `MDIV_DIV_LAT_S24 : `MDIV_DIV_LAT_U24;
        end else begin
            skip    = `MDIV_SKIP_32;
            latency = signedOp ? `MDIV_DIV_LAT_S32 : `MDIV_DIV_LAT_U32;
        end
    end

    // ======================================================================
    // restoring step: one quotient bit per clock
    always_comb begin
        shifted = {rem, quo[31]};
        trial   = {1'b0, shifted} - {2'h0, dvsr};
    end

    // sequencer: iterations finish early, the count pads to the fixed latency
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state     <= mdiv_pkg::DIV_IDLE;
            cycLeft   <= 6'h00;
            itersLeft <= 6'h00;
        end else begin
            unique case (state)
                mdiv_pkg::DIV_IDLE: begin
                    if (start) begin
                        state     <= mdiv_pkg::DIV_RUN;
                        cycLeft   <= latency - 6'h01;
                        itersLeft <= `MDIV_DIV_BITS - skip;
                    end
                end
                mdiv_pkg::DIV_RUN: begin
                    cycLeft <= cycLeft - 6'h01;
                    if (itersLeft != 6'h00) begin
                        itersLeft <= itersLeft - 6'h01;
                    end
                    if (cycLeft == 6'h01) begin
                        state <= mdiv_pkg::DIV_IDLE;
                    end
                end
            endcase
        end
    end

    // datapath registers; skipped bits are pre-shifted out of the dividend
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rem  <= 32'h0;
            quo  <= 32'h0;
            dvsr <= 32'h0;
            negQ <= 1'b0;
            negR <= 1'b0;
        end else if (state == mdiv_pkg::DIV_IDLE && start) begin
            rem  <= 32'h0;
            quo  <= magDividend << skip;
            dvsr <= magDivisor;
            negQ <= signedOp && (dividend[31] ^ divisor[31]);
            negR <= signedOp && dividend[31];
        end else if (state == mdiv_pkg::DIV_RUN && itersLeft != 6'h00) begin
            if (!trial[33]) begin
                rem <= trial[31:0];
                quo <= {quo[30:0], 1'b1};
            end else begin
                rem <= shifted[31:0];
                quo <= {quo[30:0], 1'b0};
            end
        end
    end

    // sign fix-up is applied on the way out, combinationally from quo and rem
    assign done      = (state == mdiv_pkg::DIV_RUN) && (cycLeft == 6'h01);
    assign quotient  = negQ ? (32'h0 - quo) : quo;
    assign remainder = negR ? (32'h0 - rem) : rem;

endmodule

/* File: dv/mdiv_tb_pkg.sv */
// expectation helpers shared by the bench and its checker
package mdiv_tb_pkg;

    // ==========
    // divide clocks: width class plus four, two more when signed
    function automatic int divLat(logic [31:0] a, logic s);
        logic [31:0] t;
        for (int w = 8; w < 32; w += 8) begin
            t = s ? 32'($signed(a) >>> (w - 1)) : a >> w;
            if (t == 32'h0 || (s && t == 32'hFFFFFFFF)) begin
                return w + 4 + (s ? 2 : 0);
            end
        end
        return s ? 38 : 36;
    endfunction

endpackage

/* File: dv/mdiv_unit_monitor.sv */
// port checker for issue, multiply result and divide timing
`timescale 1ns/10ps
`include "mdiv_params.svh"

module mdiv_unit_monitor #(
    parameter int MUL_LATENCY = `MDIV_MUL_LATENCY
) (
    input wire logic                       clk,           // core clock
    input wire logic                       rstn,          // reset, low
    input wire logic                       issueValid,    // op offered
    input wire mdiv_pkg::mdiv_op_t         issueOp,       // op code
    input wire logic                       issueSigned,   // signed
    input wire logic [`MDIV_DEST_BITS-1:0] issueDest,     // dest index
    input wire logic [31:0]                firstOperand,  // operand a
    input wire logic [31:0]                secondOperand, // operand b
    input wire logic                       issueStall,    // divide busy
    input wire logic                       gprValid,      // result pulse
    input wire logic [`MDIV_DEST_BITS-1:0] gprDest,       // its index
    input wire logic [31:0]                gprData,       // its value
    input wire logic                       divDone        // divide pulse
);
    // ==========
    // helpers
    wire        take    = issueValid && !issueStall;
    wire        gprTake = take && issueOp == mdiv_pkg::OP_MUL_GPR;
    wire        divTake = take && issueOp == mdiv_pkg::OP_DIVIDE;
    wire [31:0] prodLo  = firstOperand * secondOperand;
    int         stallCnt;
    int         expL;

    // stall run length, judged only at release
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stallCnt <= 0;
        end else begin
            stallCnt <= issueStall ? stallCnt + 1 : 0;
        end
    end

    // divide length expected at take
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            expL <= 0;
        end else if (divTake) begin
            expL <= mdiv_tb_pkg::divLat(firstOperand, issueSigned);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // ==========
    // assertions
    AST_GPR_LAT: assert property (gprTake |-> ##MUL_LATENCY (gprValid
        && gprDest == $past(issueDest, MUL_LATENCY) && gprData == $past(prodLo, MUL_LATENCY)))
        else $error("gpr result wrong");
    AST_GPR_CAUSE: assert property (gprValid |-> $past(gprTake, MUL_LATENCY))
        else $error("gpr result unissued");
    AST_MUL_NOSTALL: assert property (take && issueOp != mdiv_pkg::OP_DIVIDE |=> !issueStall)
        else $error("multiply caused a stall");
    AST_DIV_HOLD: assert property (divTake |=> issueStall [*8])
        else $error("no divide stall");
    AST_DIV_BOUND: assert property (divTake |-> ##[12:38] divDone)
        else $error("divide too slow");
    AST_DIV_LEN: assert property ($fell(issueStall) |-> stallCnt == expL - 1)
        else $error("divide length wrong");
    AST_DONE_FALL: assert property (divDone |-> $fell(issueStall))
        else $error("done apart from release");
    AST_STALL_CAUSE: assert property ($rose(issueStall) |-> $past(divTake))
        else $error("stall without a divide");
endmodule

bind mdiv_unit mdiv_unit_monitor #(.MUL_LATENCY(MUL_LATENCY)) u_mdiv_unit_monitor (
    .clk(clk), .rstn(rstn), .issueValid(issueValid), .issueOp(issueOp),
    .issueSigned(issueSigned), .issueDest(issueDest), .firstOperand(firstOperand),
    .secondOperand(secondOperand), .issueStall(issueStall), .gprValid(gprValid),
    .gprDest(gprDest), .gprData(gprData), .divDone(divDone));

/* File: dv/mdiv_issue_model.sv */
// integer pipeline model that offers operations to the unit
`timescale 1ns/10ps

module mdiv_issue_model (
    input  wire logic         clk,           // core clock
    input  wire logic         issueStall,    // unit busy dividing
    output logic              issueValid,    // operation offered
    output mdiv_pkg::mdiv_op_t issueOp,      // operation code
    output logic              issueSigned,   // signed variant
    output logic [1:0]        issuePair,     // target pair
    output logic [4:0]        issueDest,     // general reg index
    output logic [31:0]       firstOperand,  // first operand
    output logic [31:0]       secondOperand  // second operand
);
    // ==========
    // idle operands hold a pattern, not zero
    initial begin
        {issueValid, issueSigned, issuePair, issueDest} = 9'h0;
        issueOp = mdiv_pkg::OP_MUL_PAIR;
        firstOperand = 32'hA5A5A5A5;
        secondOperand = 32'h5A5A5A5A;
    end

    // offer at negedge, hold until taken
    task automatic send(mdiv_pkg::mdiv_op_t o, logic s, logic [1:0] p, logic [4:0] d,
                        logic [31:0] a, logic [31:0] b);
        @(negedge clk);
        {issueValid, issueOp, issueSigned, issuePair, issueDest} = {1'b1, o, s, p, d};
        {firstOperand, secondOperand} = {a, b};
        while (issueStall) @(negedge clk);
        @(posedge clk);
    endtask

    // flip released operands so stale ones cannot pass
    task automatic idle();
        @(negedge clk);
        issueValid = 1'b0;
        firstOperand = ~firstOperand;
        secondOperand = ~secondOperand;
    endtask
endmodule

/* File: dv/test_mdiv_unit.sv */
// self-checking bench of the multiply/divide unit
`timescale 1ns/10ps
`include "mdiv_params.svh"

module test_mdiv_unit;
    localparam int MUL_LAT = `MDIV_MUL_LATENCY;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [1:0] readPair = 2'h0;
    logic issueValid, issueSigned, issueStall, gprValid, divDone;
    mdiv_pkg::mdiv_op_t issueOp, o;
    logic [1:0] issuePair;
    logic [4:0] issueDest, gprDest;
    logic [31:0] firstOperand, secondOperand, gprData, readUpper, readLower, a, b;
    logic [31:0] corner [4] = '{32'h80000000, 32'hFFFFFFFF, 32'h7FFFFFFF, 32'h0000FFFF};
    logic [63:0] acc [4] = '{default: 64'h0};
    logic [68:0] gprQ [$];
    int divQ [$];
    int errors = 0;
    int n_tests = 0;
    int cyc = 0;
    int lastTake, t, w;
    logic s;

    always #2 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    mdiv_issue_model u_mdiv_issue_model (.clk(clk), .issueStall(issueStall),
        .issueValid(issueValid), .issueOp(issueOp), .issueSigned(issueSigned),
        .issuePair(issuePair), .issueDest(issueDest), .firstOperand(firstOperand),
        .secondOperand(secondOperand));
    mdiv_unit u_mdiv_unit (.clk(clk), .rstn(rstn),
        .issueValid(issueValid), .issueOp(issueOp), .issueSigned(issueSigned),
        .issuePair(issuePair), .issueDest(issueDest), .firstOperand(firstOperand),
        .secondOperand(secondOperand), .readPair(readPair), .issueStall(issueStall),
        .gprValid(gprValid), .gprDest(gprDest), .gprData(gprData), .divDone(divDone),
        .readUpper(readUpper), .readLower(readLower));

    // ==========
    // compare, count and close
    task automatic chk(string name, logic [68:0] seen, logic [68:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // pulses matched in issue order at their due cycle
    always @(posedge clk) begin
        if (gprValid === 1'b1) chk("gpr", {32'(cyc), gprDest, gprData}, gprQ.pop_front());
        if (divDone === 1'b1) chk("divDone", 69'(cyc), 69'(divQ.pop_front()));
    end

    // ==========
    // issue one op, update the model
    task automatic op(mdiv_pkg::mdiv_op_t o, logic s, logic [1:0] p, logic [4:0] d,
                      logic [31:0] a, logic [31:0] b);
        logic signed [63:0] pr;
        logic signed [63:0] dt;
        if (s) pr = $signed(a) * $signed(b);
        else pr = a * b;
        dt = $signed(a[15:0]) * $signed(b[15:0]) + $signed(a[31:16]) * $signed(b[31:16]);
        u_mdiv_issue_model.send(o, s, p, d, a, b);
        lastTake = cyc;
        case (o)
            mdiv_pkg::OP_MUL_PAIR: acc[p] = pr;
            mdiv_pkg::OP_MUL_ACC: acc[p] += pr;
            mdiv_pkg::OP_MUL_SUB: acc[p] -= pr;
            mdiv_pkg::OP_SPX_DOT_ADD: acc[p] += dt;
            mdiv_pkg::OP_SPX_DOT_SUB: acc[p] -= dt;
            mdiv_pkg::OP_MOVE_UPPER: acc[p][63:32] = a;
            mdiv_pkg::OP_MOVE_LOWER: acc[p][31:0] = a;
            mdiv_pkg::OP_MUL_GPR: gprQ.push_back({32'(lastTake + MUL_LAT), d, pr[31:0]});
            default: begin
                divQ.push_back(lastTake + mdiv_tb_pkg::divLat(a, s));
                if (s) acc[p] = {32'($signed(a) % $signed(b)), 32'($signed(a) / $signed(b))};
                else acc[p] = {a % b, a / b};
            end
        endcase
    endtask

    // drain, then read each pair
    task automatic readAll();
        u_mdiv_issue_model.idle();
        repeat (50) @(negedge clk);
        for (int i = 0; i < 4; i++) begin
            readPair = 2'(i);
            @(negedge clk);
            @(negedge clk);
            chk("pair", {5'h0, readUpper, readLower}, {5'h0, acc[i]});
        end
    endtask

    initial begin
        #200000;
        errors++;
        results();
    end

    initial begin
        void'($urandom(4));
        repeat (12) @(negedge clk);
        rstn = 1'b1;
        readAll();
        // every kind back to back, then accumulate
        for (int k = 0; k < 18; k++) op(mdiv_pkg::mdiv_op_t'(k % 9), k[0], 2'(k), 5'(k),
            corner[k % 4], corner[(k + 1) % 4]);
        for (int k = 0; k < 4; k++) op(mdiv_pkg::OP_MUL_ACC, 1'b1, 2'h0, 5'h0, corner[k],
            corner[3 - k]);
        readAll();
        // each dividend class and sign, a multiply waiting
        for (int k = 0; k < 8; k++) begin
            w = 8 * (k / 2 + 1);
            a = k[0] ? -(32'h1 << (w - 1)) : 32'h1 << (w - 1);
            op(mdiv_pkg::OP_DIVIDE, k[0], 2'(k), 5'h0, a, 32'h3);
            t = lastTake;
            op(mdiv_pkg::OP_MUL_GPR, 1'b0, 2'h0, 5'(k), a, 32'h3);
            chk("div repeat", 69'(lastTake - t), 69'(w + 4 + 2 * k[0]));
        end
        // random mix; divisor bit one set keeps it nonzero
        repeat (300) begin
            o = mdiv_pkg::mdiv_op_t'($urandom_range(0, 8));
            a = $urandom >> (8 * $urandom_range(0, 3));
            b = $urandom | 32'h2;
            s = 1'($urandom);
            if (s && $urandom_range(0, 1) == 1) a = -a;
            op(o, s, 2'($urandom), 5'($urandom), a, b);
            if ($urandom_range(0, 3) == 0) u_mdiv_issue_model.idle();
        end
        readAll();
        results();
    end
endmodule
